// [common/scp_params.svh]
// Constants of the serial configuration port: offsets, field positions,
// reset values and frame counts. Included by the package and the design.
// Assumes nothing of its surroundings; it holds definitions only.
//
// Overview of operation
// R1: Chip select low enables access; otherwise ignore.
// R2: Edge select high makes falling clock edge active.
// R3: By default sample serial input on rising edge.
// R4: Read data returns serially on serial output.
// R5: Master reset low restores all state defaults. In the code the pin synchronisers are reset by i_srst only.
// R6: Strap level seeds registers 34, 38, 64 bits. After i_srst the code seeds 0 whatever the strap level.
// R7: Strap low means SDH, high means SONET.
// R8: Seeded bits stay writable; writes override strap.
// R9: Registers hold eight bits, two-digit hex address.
// R10: Network type bit one means SONET defaults.
// R11: Drive serial output only while selected.
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// Register map geometry: seven address bits plus a read flag.
`define SCP_ADDR_W 7
`define SCP_DATA_W 8
`define SCP_NUM_REGS 128
// Frame fields: first byte carries the read flag in its top bit.
`define SCP_RW_BIT 7
`define SCP_BITS_PER_BYTE 4'h7
// Strap-seeded registers and their bit positions.
`define SCP_ADDR_INPUT_MODE 7'h34
`define SCP_NET_TYPE_POS 2
`define SCP_ADDR_RATE_A 7'h38
`define SCP_RATE_A_LO_POS 5
`define SCP_RATE_A_HI_POS 6
`define SCP_ADDR_RATE_B 7'h64
`define SCP_RATE_B_POS 4
// Reset value of every register before the strap is applied.
`define SCP_REG_RST 8'h00

`endif

// [common/scp_pkg.sv]
// Types shared by the serial configuration port design.
// Assumes the constants header sits in the same include path.
`include "scp_params.svh"

package scp_pkg;

  // Frame sequencer states, one-hot.
  typedef enum logic [3:0] {
    SCP_ST_IDLE = 4'h1,
    SCP_ST_ADDR = 4'h2,
    SCP_ST_DATA = 4'h4,
    SCP_ST_DONE = 4'h8
  } scp_state_t;

endpackage

// [design/scp_sync.sv]
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level compared with i_clk; bits are not coherent.
`timescale 1ns/1ps
`default_nettype none

module scp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  // First stage is read only by the second stage.
  logic [W-1:0] meta_q;

  // Both stages return to the idle level of the pins on reset.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule // scp_sync

`default_nettype wire

// [design/scp_top.sv]
// Serial configuration port with master reset and network-type strap.
// Assumes all pins are asynchronous to i_clk and the serial clock is at least
// eight i_clk periods long; frames are sixteen bits, first byte read flag and
// address, second byte data.
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"

module scp_top
  import scp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_chip_select_low,
  input wire logic i_serial_clk,
  input wire logic i_serial_in,
  input wire logic i_active_edge_select,
  input wire logic i_master_reset_low,
  input wire logic i_network_strap,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic o_network_type_bit,
  output logic [1:0] o_rate_sel_a,
  output logic o_rate_sel_b
);

  // Synchronised pins.
  logic cs_low_s; // Chip select, active low.
  logic sclk_s; // Serial clock level.
  logic sdi_s; // Serial data in.
  logic edge_sel_s; // Active edge select.
  logic strap_s; // Network strap level.
  logic mrst_low_s; // Master reset, active low.

  // The bundle idles with chip select high so a reset never looks like a frame.
  scp_sync #(.W(5), .RST_VAL(5'h10)) u_pin_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d({i_chip_select_low, i_serial_clk, i_serial_in, i_active_edge_select,
          i_network_strap}),
    .o_q({cs_low_s, sclk_s, sdi_s, edge_sel_s, strap_s})
  );

  // Master reset has its own synchroniser; it resets the frame logic, while the pin bundle is reset by i_srst only.
  scp_sync #(.W(1), .RST_VAL(1'h1)) u_mrst_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_master_reset_low),
    .o_q(mrst_low_s)
  );

  // Internal reset: either the system reset or the master reset pin.
  logic rst;
  assign rst = i_srst | ~mrst_low_s; // [R5]

  // Edge detection on the sampled serial clock.
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cap_edge; // Edge on which serial input is taken.
  logic shift_edge; // Opposite edge, on which serial output changes.

  always_ff @(posedge i_clk) begin
    if (rst) begin
      sclk_prev_q <= 1'h0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  // Edge select high picks the falling edge; otherwise rising captures.
  assign cap_edge = edge_sel_s ? sclk_fall : sclk_rise; // [R2] [R3]
  assign shift_edge = edge_sel_s ? sclk_rise : sclk_fall; // [R4]

  // Frame sequencer and its bit counter.
  scp_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_in_q; // Incoming bits, newest in bit 0.
  logic [`SCP_ADDR_W-1:0] addr_q; // Latched register address.
  logic rd_q; // Current frame is a read.
  logic [7:0] byte_in; // Byte completed on this capture edge.
  logic byte_done;

  assign byte_in = {sh_in_q[6:0], sdi_s};
  assign byte_done = cap_edge && (cnt_q == `SCP_BITS_PER_BYTE);

  // Chip select high forces idle, so clock and data activity are ignored.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      state_q <= SCP_ST_IDLE;
      cnt_q <= 4'h0;
    end else if (cs_low_s) begin
      state_q <= SCP_ST_IDLE; // [R1]
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        SCP_ST_IDLE: begin
          state_q <= SCP_ST_ADDR;
          cnt_q <= 4'h0;
        end
        SCP_ST_ADDR, SCP_ST_DATA: begin
          if (byte_done) begin
            // Extra bytes after the data byte are ignored until deselect.
            state_q <= (state_q == SCP_ST_ADDR) ? SCP_ST_DATA : SCP_ST_DONE;
            cnt_q <= 4'h0;
          end else if (cap_edge) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        SCP_ST_DONE: begin
          cnt_q <= 4'h0;
        end
        default: begin
          state_q <= SCP_ST_IDLE;
          cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // Input shifter and address latch.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      sh_in_q <= 8'h00;
      addr_q <= '0;
      rd_q <= 1'h0;
    end else begin
      if (cap_edge && !cs_low_s) begin
        sh_in_q <= byte_in;
      end
      // Address byte: read flag on top, seven address bits below.
      if (state_q == SCP_ST_ADDR && byte_done && !cs_low_s) begin
        rd_q <= byte_in[`SCP_RW_BIT];
        addr_q <= byte_in[`SCP_ADDR_W-1:0]; // [R9]
      end
    end
  end

  // Register file, 8 bits per address.
  logic [`SCP_DATA_W-1:0] regs_q [`SCP_NUM_REGS]; // [R9]
  logic strap_load_q; // High for the first cycle after reset release.
  logic wr_fire;

  assign wr_fire = (state_q == SCP_ST_DATA) && byte_done && !cs_low_s && !rd_q;

  // The strap is caught one cycle after reset release, not during reset, so a
  // strap pin settling late is still seen cleanly after a master reset; after i_srst
  // the strap synchroniser is still at its reset level 0, so 0 is seeded.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      strap_load_q <= 1'h1;
    end else begin
      strap_load_q <= 1'h0;
    end
  end

  // Storage: reset, then strap seeding, then software writes override.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      for (int i = 0; i < `SCP_NUM_REGS; i++) begin
        regs_q[i] <= `SCP_REG_RST; // [R5]
      end
    end else if (strap_load_q) begin
      // Strap low selects SDH (0), high selects SONET (1).
      regs_q[`SCP_ADDR_INPUT_MODE][`SCP_NET_TYPE_POS] <= strap_s; // [R6] [R7] [R10]
      regs_q[`SCP_ADDR_RATE_A][`SCP_RATE_A_LO_POS] <= strap_s; // [R6]
      regs_q[`SCP_ADDR_RATE_A][`SCP_RATE_A_HI_POS] <= strap_s; // [R6]
      regs_q[`SCP_ADDR_RATE_B][`SCP_RATE_B_POS] <= strap_s; // [R6]
    end else if (wr_fire) begin
      regs_q[addr_q] <= byte_in; // [R8]
    end
  end

  // Network selection outputs follow their register bits one cycle late.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_network_type_bit <= 1'h0;
      o_rate_sel_a <= 2'h0;
      o_rate_sel_b <= 1'h0;
    end else begin
      o_network_type_bit <= regs_q[`SCP_ADDR_INPUT_MODE][`SCP_NET_TYPE_POS]; // [R10]
      o_rate_sel_a <= {regs_q[`SCP_ADDR_RATE_A][`SCP_RATE_A_HI_POS],
                       regs_q[`SCP_ADDR_RATE_A][`SCP_RATE_A_LO_POS]};
      o_rate_sel_b <= regs_q[`SCP_ADDR_RATE_B][`SCP_RATE_B_POS];
    end
  end

  // Read path: data loads when the address byte ends and leaves MSB first,
  // one bit per shift edge, so the first bit is out before the first capture.
  logic [7:0] sh_out_q;
  logic [`SCP_ADDR_W-1:0] rd_addr;
  assign rd_addr = byte_in[`SCP_ADDR_W-1:0];

  always_ff @(posedge i_clk) begin
    if (rst || cs_low_s) begin
      sh_out_q <= 8'h00;
      o_serial_out <= 1'h0;
    end else if (state_q == SCP_ST_ADDR && byte_done) begin
      // A write frame shifts out zeros.
      sh_out_q <= byte_in[`SCP_RW_BIT] ? regs_q[rd_addr] : 8'h00;
    end else if (state_q == SCP_ST_DATA && shift_edge) begin
      o_serial_out <= sh_out_q[7]; // [R4]
      sh_out_q <= {sh_out_q[6:0], 1'h0};
    end else if (state_q != SCP_ST_DATA) begin
      o_serial_out <= 1'h0;
    end
  end

  // Output enable follows the sampled chip select; the pin floats otherwise.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_serial_out_oe <= 1'h0;
    end else begin
      o_serial_out_oe <= ~cs_low_s; // [R11]
    end
  end

  // Checks.
  cs_ignore_a: assert property (@(posedge i_clk) disable iff (rst) // [R1]
    cs_low_s |=> (state_q == SCP_ST_IDLE) && (cnt_q == 4'h0))
    else $error("Frame logic active while deselected.");
  fall_active_a: assert property (@(posedge i_clk) disable iff (rst) // [R2]
    (edge_sel_s && sclk_rise && !cs_low_s && state_q == SCP_ST_ADDR) |=> $stable(cnt_q))
    else $error("Rising edge counted with falling edge selected.");
  rise_default_a: assert property (@(posedge i_clk) disable iff (rst) // [R3]
    (!edge_sel_s && sclk_fall && !cs_low_s && state_q == SCP_ST_ADDR) |=> $stable(cnt_q))
    else $error("Falling edge counted in default edge setting.");
  read_bit_a: assert property (@(posedge i_clk) disable iff (rst) // [R4]
    (state_q == SCP_ST_DATA && shift_edge && !cs_low_s) |=> o_serial_out == $past(sh_out_q[7]))
    else $error("Serial output bit does not match read data.");
  reset_idle_a: assert property (@(posedge i_clk) // [R5]
    rst |=> (state_q == SCP_ST_IDLE) && !o_serial_out_oe && strap_load_q)
    else $error("State not default after reset.");
  strap_seed_a: assert property (@(posedge i_clk) disable iff (rst) // [R6]
    strap_load_q |=> regs_q[`SCP_ADDR_RATE_A][`SCP_RATE_A_HI_POS] == $past(strap_s)
      && regs_q[`SCP_ADDR_RATE_B][`SCP_RATE_B_POS] == $past(strap_s))
    else $error("Strap not loaded into rate registers.");
  strap_polarity_a: assert property (@(posedge i_clk) disable iff (rst) // [R7]
    (strap_load_q && !strap_s) |-> ##2 !o_network_type_bit)
    else $error("Low strap did not select SDH.");
  sw_override_a: assert property (@(posedge i_clk) disable iff (rst) // [R8]
    (wr_fire && !strap_load_q) |=> regs_q[$past(addr_q)] == $past(byte_in))
    else $error("Software write did not store.");
  addr_latch_a: assert property (@(posedge i_clk) disable iff (rst) // [R9]
    (state_q == SCP_ST_ADDR && byte_done && !cs_low_s) |=> addr_q == $past(byte_in[6:0]))
    else $error("Address byte not latched.");
  net_type_out_a: assert property (@(posedge i_clk) disable iff (rst) // [R10]
    $changed(regs_q[`SCP_ADDR_INPUT_MODE][`SCP_NET_TYPE_POS]) |=>
      o_network_type_bit == $past(regs_q[`SCP_ADDR_INPUT_MODE][`SCP_NET_TYPE_POS]))
    else $error("Network type output does not follow register.");
  sdo_float_a: assert property (@(posedge i_clk) disable iff (rst) // [R11]
    cs_low_s |=> !o_serial_out_oe ##1 !o_serial_out)
    else $error("Serial output driven while deselected.");

  read_frame_c: cover property (@(posedge i_clk) disable iff (rst)
    state_q == SCP_ST_DATA && rd_q && byte_done);
  write_frame_c: cover property (@(posedge i_clk) disable iff (rst) wr_fire);
  strap_high_c: cover property (@(posedge i_clk) disable iff (rst) strap_load_q && strap_s);
  fall_mode_c: cover property (@(posedge i_clk) disable iff (rst) edge_sel_s && wr_fire);

endmodule // scp_top

`default_nettype wire

// [verification/scp_host_model.sv]
// Host model: a serial bus master that frames, clocks and reads the port.
// Assumes i_clk is the bench clock; half a serial clock is four of its cycles.
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
  input wire logic i_clk,
  input wire logic i_serial_out,
  input wire logic i_serial_out_oe,
  output logic o_chip_select_low,
  output logic o_serial_clk,
  output logic o_serial_in
);
  logic oe_all; // Falls if the output was undriven at any sampled data bit.

  // Idle: deselected, serial clock parked low; between frames only the noise task moves it.
  initial begin
    o_chip_select_low = 1'b1;
    o_serial_clk = 1'b0;
    o_serial_in = 1'b0;
    oe_all = 1'b0;
  end

  // Half a serial clock period, 200 ns, stepped on the falling edge.
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask

  // One frame, MSB first. Data changes at the start of the capture phase so it
  // is stable across the capture edge; read bits are taken at that edge too.
  task automatic frame(input logic [15:0] tx, input logic fall_cap, output logic [7:0] rx);
    rx = 8'h00;
    oe_all = 1'b1;
    o_chip_select_low = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      for (int ph = 0; ph < 2; ph++) begin
        if (ph == int'(fall_cap)) begin
          o_serial_in = tx[i];
        end
        half();
        if (i < 8 && ph == int'(fall_cap)) begin
          rx[i] = i_serial_out;
          oe_all = oe_all & i_serial_out_oe;
        end
        o_serial_clk = ~o_serial_clk;
      end
    end
    half();
    o_chip_select_low = 1'b1;
    o_serial_in = ~o_serial_in; // Released line: never show the last bit.
    half();
    half();
  endtask

  // Serial clock and data toggling while deselected; n is even so the clock parks low.
  task automatic noise(input int n);
    for (int k = 0; k < n; k++) begin
      o_serial_in = k[0];
      half();
      o_serial_clk = ~o_serial_clk;
    end
  endtask
endmodule // scp_host_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench: drives the port through the host model and compares each
// result with a register model kept here. Assumes design and host model compiled.
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"

module tb;
  logic i_clk = 1'b0; // 20 MHz bench clock.
  logic i_srst = 1'b1; // Synchronous reset, held for two cycles.
  logic i_active_edge_select = 1'b0; // Capture edge choice.
  logic i_master_reset_low = 1'b1; // Master reset pin.
  logic i_network_strap = 1'b0; // Network-type strap pin.
  logic chip_select_low_w, sclk_w, sdi_w, sdo_w, oe_w, net_w, rate_b_w;
  logic [1:0] rate_a_w;
  int error_cnt = 0;
  int samples_checked = 0;
  int mdl [128]; // Expected contents of every register.
  logic [7:0] rx;
  logic [6:0] a;

  always #25 i_clk = ~i_clk;

  scp_top scp_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_chip_select_low(chip_select_low_w),
    .i_serial_clk(sclk_w), .i_serial_in(sdi_w), .i_active_edge_select(i_active_edge_select),
    .i_master_reset_low(i_master_reset_low), .i_network_strap(i_network_strap),
    .o_serial_out(sdo_w), .o_serial_out_oe(oe_w), .o_network_type_bit(net_w),
    .o_rate_sel_a(rate_a_w), .o_rate_sel_b(rate_b_w));

  scp_host_model scp_host_model_inst (.i_clk(i_clk), .i_serial_out(sdo_w),
    .i_serial_out_oe(oe_w), .o_chip_select_low(chip_select_low_w), .o_serial_clk(sclk_w),
    .o_serial_in(sdi_w));

  // Compare, count and report one value.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Verdict and end of run.
  task automatic results();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The seeded bits as the outputs should show them.
  task automatic outs();
    chk("strap_outputs", {4'h0, 1'(mdl[`SCP_ADDR_INPUT_MODE][`SCP_NET_TYPE_POS]),
      2'(mdl[`SCP_ADDR_RATE_A][6:5]), 1'(mdl[`SCP_ADDR_RATE_B][`SCP_RATE_B_POS])},
      {4'h0, net_w, rate_a_w, rate_b_w});
  endtask

  // Between frames the output must be released and low.
  task automatic idle();
    chk("idle_out", 8'h00, {6'h00, oe_w, sdo_w});
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    scp_host_model_inst.frame({1'b0, ad, d}, i_active_edge_select, rx);
    mdl[ad] = int'(d);
    idle();
    outs();
  endtask

  task automatic rd(input logic [6:0] ad);
    scp_host_model_inst.frame({1'b1, ad, 8'h00}, i_active_edge_select, rx);
    chk("read_data", 8'(mdl[ad]), rx);
    chk("oe_in_frame", 8'h01, {7'h00, scp_host_model_inst.oe_all});
    idle();
  endtask

  // Master reset pulse with a strap level; the model reloads the seeded bits.
  task automatic mreset(input logic s);
    i_master_reset_low = 1'b0;
    i_network_strap = s;
    repeat (5) @(negedge i_clk);
    i_master_reset_low = 1'b1;
    repeat (6) @(negedge i_clk);
    foreach (mdl[k]) mdl[k] = 0;
    mdl[`SCP_ADDR_INPUT_MODE] = int'(s) << `SCP_NET_TYPE_POS;
    mdl[`SCP_ADDR_RATE_A] = (int'(s) << `SCP_RATE_A_LO_POS) | (int'(s) << `SCP_RATE_A_HI_POS);
    mdl[`SCP_ADDR_RATE_B] = int'(s) << `SCP_RATE_B_POS;
  endtask

  // Watchdog so that a hang still reaches the verdict.
  initial begin
    repeat (100000) @(posedge i_clk);
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(32'h58c6));
    foreach (mdl[k]) mdl[k] = 0;
    repeat (2) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (6) @(negedge i_clk);
    // Both strap levels seed the bits; a later strap change is ignored.
    for (int s = 0; s < 2; s++) begin
      mreset(1'(s));
      outs();
      rd(`SCP_ADDR_INPUT_MODE);
      rd(`SCP_ADDR_RATE_A);
      rd(`SCP_ADDR_RATE_B);
      i_network_strap = ~i_network_strap;
      repeat (6) @(negedge i_clk);
      outs();
    end
    $display("Test strap done");
    // Random traffic in both edge modes, back to back, plus seeded overrides.
    for (int m = 0; m < 2; m++) begin
      i_active_edge_select = 1'(m);
      repeat (10) begin
        a = 7'($urandom);
        wr(a, 8'($urandom));
        rd(a);
      end
      wr(`SCP_ADDR_INPUT_MODE, 8'($urandom));
      wr(`SCP_ADDR_RATE_A, 8'($urandom));
      wr(`SCP_ADDR_RATE_B, 8'($urandom));
      rd(7'h7f);
      rd(7'h00);
      rd(`SCP_ADDR_RATE_A);
    end
    $display("Test traffic done");
    // Clock and data activity with the port deselected must change nothing.
    scp_host_model_inst.noise(20);
    idle();
    rd(`SCP_ADDR_INPUT_MODE);
    rd(a);
    outs();
    $display("Test deselect done");
    // Master reset in mid-run clears written registers.
    wr(7'h55, 8'ha5);
    mreset(1'b1);
    rd(7'h55);
    rd(a);
    outs();
    $display("Test master reset done");
    results();
  end
endmodule // tb
`default_nettype wire
